// ### src/dic_pkg.sv
package dic_pkg;
   // Register map, byte addresses on the bus
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_WIN0 = 8'h04;
   localparam logic [7:0] ADDR_WIN1 = 8'h08;
   localparam logic [7:0] ADDR_LINE_INV = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;

   // Cache control register fields
   localparam int CACHE_ENABLE_BIT = 31;
   localparam int LINE_INVALIDATE_DISABLE = 28;
   localparam int FREEZE_BIT = 27;
   localparam int FULL_INVALIDATE_REQUEST = 24;
   localparam int BUFFER_NONCACHE_BIT = 10;
   localparam int DEFAULT_INHIBIT = 9;
   localparam int DEFAULT_BUFWR = 8;
   localparam int DEFAULT_WPROT = 5;
   localparam int LINE_FILL_POLICY_LO = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK = 32'h9900_0723;

   // Access window fields
   localparam int WIN_BASE_LO = 24;
   localparam int WIN_MASK_LO = 16;
   localparam int WIN_ENABLE = 15;
   localparam int WIN_INHIBIT = 6;
   localparam int WIN_PRECISE = 5;
   localparam int WIN_WPROT = 2;
   localparam logic [31:0] WIN_RESET = 32'h0000_0000;
   localparam logic [31:0] WIN_WMASK = 32'hFFFF_8064;

   // Effective attribute vector
   localparam int ATTR_CACHE = 2;
   localparam int ATTR_PRECISE = 1;
   localparam int ATTR_WPROT = 0;

   // Geometry
   localparam int LINES = 32;
   localparam int WORDS = 4;
   localparam int TAG_W = 23;
   localparam logic [4:0] SWEEP_LAST = 5'h1F;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef enum logic [1:0] {
      EXT_IDLE = 2'b00,
      EXT_RUN = 2'b01
   } dic_ext_t;
endpackage

// ### src/dic_attr_resolve.sv
`timescale 1ns/1ns
module dic_attr_resolve (
   input wire logic [31:0] addr,
   input wire logic [31:0] win0,
   input wire logic [31:0] win1,
   input wire logic [31:0] ctrl,
   output logic [2:0] attr
);
   function automatic logic winMatch(input logic [31:0] win, input logic [31:0] a);
      winMatch = win[dic_pkg::WIN_ENABLE] &&
         (((a[31:24] ^ win[31:dic_pkg::WIN_BASE_LO]) & ~win[23:dic_pkg::WIN_MASK_LO]) == 8'h00);
   endfunction

   function automatic logic [2:0] winAttr(input logic [31:0] win);
      winAttr = {~win[dic_pkg::WIN_INHIBIT], win[dic_pkg::WIN_PRECISE], win[dic_pkg::WIN_WPROT]};
   endfunction

   // First window wins, then second, then the defaults
   always_comb begin
      if (winMatch(win0, addr)) begin
         attr = winAttr(win0);
      end else if (winMatch(win1, addr)) begin
         attr = winAttr(win1);
      end else begin
         attr = {~ctrl[dic_pkg::DEFAULT_INHIBIT], ~ctrl[dic_pkg::DEFAULT_BUFWR],
            ctrl[dic_pkg::DEFAULT_WPROT]};
      end
   end
endmodule

// ### src/dic_icache.sv
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
module dic_icache (
   input wire logic clk,
   input wire logic nrst,
   input wire logic fetchReq,
   input wire logic [31:0] fetchAddr,
   input wire logic localMemHit,
   output logic fetchAck,
   output logic [31:0] fetchData,
   output logic [2:0] fetchAttr,
   output logic extReq,
   output logic [31:0] extAddr,
   input wire logic extAck,
   input wire logic [31:0] extData,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp
);
   logic [31:0] cacheControlRegister_q;
   logic [31:0] accessWindowZero_q;
   logic [31:0] accessWindowOne_q;
   logic [dic_pkg::TAG_W-1:0] tag_q [dic_pkg::LINES];
   logic [dic_pkg::LINES-1:0] valid_q;
   logic [31:0] data_q [dic_pkg::LINES*dic_pkg::WORDS];
   logic [27:0] fbLine_q;
   logic [31:0] fbData_q [dic_pkg::WORDS];
   logic [3:0] fbValid_q;
   logic fbMru_q;
   logic fbKeep_q;
   logic [4:0] sweepCnt_q;
   dic_pkg::dic_ext_t extState_q;
   logic extReq_q;
   logic [31:0] extAddr_q;
   logic [1:0] extLeft_q;
   logic fetchAck_q;
   logic [31:0] fetchData_q;
   logic [2:0] fetchAttr_q;
   logic dpValid_q;
   logic dpWrite_q;
   logic dpSizeOk_q;
   logic [7:0] dpAddr_q;
   logic hreadyout_q;
   logic [31:0] hrdata_q;
   logic hresp_q;

   logic [4:0] idx;
   logic [1:0] wrd;
   logic [4:0] fbIdx;
   logic [1:0] extWord;
   logic enabled;
   logic sweeping;
   logic arrHit;
   logic fbHit;
   logic [31:0] arrWord;
   logic take;
   logic missStart;
   logic [2:0] attr;
   logic cacheable;
   logic useBuf;
   logic isLine;
   logic copyEn;
   logic wrEn;
   logic ctrlWr;
   logic linvWr;
   logic linvDo;
   logic fillBeat;

   // Small policy fields in 01 mean offsets 2 and 3 stay single longwords
   function automatic logic lineFetch(input logic [1:0] pol, input logic [1:0] off);
      lineFetch = pol[1] || !((pol == 2'h0 && off == 2'h3) || (pol == 2'h1 && off[1]));
   endfunction

   function automatic logic [31:0] regRead(input logic [7:0] a);
      case (a)
         dic_pkg::ADDR_CTRL: regRead = cacheControlRegister_q;
         dic_pkg::ADDR_WIN0: regRead = accessWindowZero_q;
         dic_pkg::ADDR_WIN1: regRead = accessWindowOne_q;
         dic_pkg::ADDR_STATUS: regRead = {24'h00_0000, fbValid_q, 1'h0, fbMru_q,
            extReq_q, sweeping};
         default: regRead = 32'h0000_0000;
      endcase
   endfunction

   dic_attr_resolve uAttr (
      .addr(fetchAddr),
      .win0(accessWindowZero_q),
      .win1(accessWindowOne_q),
      .ctrl(cacheControlRegister_q),
      .attr(attr)
   );

   assign idx = fetchAddr[8:4];
   assign wrd = fetchAddr[3:2];
   assign fbIdx = fbLine_q[4:0];
   assign extWord = extAddr_q[3:2];
   assign enabled = cacheControlRegister_q[dic_pkg::CACHE_ENABLE_BIT];
   assign sweeping = cacheControlRegister_q[dic_pkg::FULL_INVALIDATE_REQUEST];
   assign arrWord = data_q[{idx, wrd}];
   assign arrHit = enabled && valid_q[idx] && (tag_q[idx] == fetchAddr[31:9]);
   assign fbHit = (fbLine_q == fetchAddr[31:4]) && fbValid_q[wrd];
   // No source distinction: core and debug fetches share this path
   assign take = fetchReq && !fetchAck_q && !localMemHit && !sweeping;
   assign missStart = take && !arrHit && !fbHit && (extState_q == dic_pkg::EXT_IDLE);
   assign cacheable = enabled && attr[dic_pkg::ATTR_CACHE];
   assign useBuf = cacheable || (enabled && cacheControlRegister_q[dic_pkg::BUFFER_NONCACHE_BIT]);
   assign isLine = useBuf && lineFetch(cacheControlRegister_q[1:0], wrd);
   // Freeze keeps valid lines; an invalid slot may still be filled
   assign copyEn = missStart && enabled && (&fbValid_q) && fbMru_q && fbKeep_q &&
      !(cacheControlRegister_q[dic_pkg::FREEZE_BIT] && valid_q[fbIdx]);
   assign fillBeat = extReq_q && extAck;
   assign wrEn = dpValid_q && dpWrite_q && dpSizeOk_q;
   assign ctrlWr = wrEn && (dpAddr_q == dic_pkg::ADDR_CTRL);
   assign linvWr = wrEn && (dpAddr_q == dic_pkg::ADDR_LINE_INV);
   assign linvDo = linvWr && !cacheControlRegister_q[dic_pkg::LINE_INVALIDATE_DISABLE];

   // Bus slave: every accepted transfer gets one wait state so reads see prior writes
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dpValid_q <= 1'h0;
         dpWrite_q <= 1'h0;
         dpSizeOk_q <= 1'h0;
         dpAddr_q <= 8'h00;
         hreadyout_q <= 1'h1;
         hrdata_q <= 32'h0000_0000;
         hresp_q <= 1'h0;
      end else begin
         hresp_q <= 1'h0;
         if (hsel && hready && htrans == dic_pkg::HTRANS_NONSEQ) begin
            dpValid_q <= 1'h1;
            dpWrite_q <= hwrite;
            dpSizeOk_q <= (hsize == dic_pkg::HSIZE_WORD);
            dpAddr_q <= haddr[7:0];
            hreadyout_q <= 1'h0;
         end else if (dpValid_q) begin
            dpValid_q <= 1'h0;
            hreadyout_q <= 1'h1;
            hrdata_q <= (dpWrite_q || !dpSizeOk_q) ? 32'h0000_0000 : regRead(dpAddr_q);
         end
      end
   end

   // A software write that re-requests the sweep on its last cycle wins over the clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cacheControlRegister_q <= dic_pkg::CTRL_RESET;
         accessWindowZero_q <= dic_pkg::WIN_RESET;
         accessWindowOne_q <= dic_pkg::WIN_RESET;
      end else begin
         if (sweeping && sweepCnt_q == dic_pkg::SWEEP_LAST) begin
            cacheControlRegister_q[dic_pkg::FULL_INVALIDATE_REQUEST] <= 1'h0;
         end
         if (ctrlWr) begin
            cacheControlRegister_q <= hwdata & dic_pkg::CTRL_WMASK;
         end
         if (wrEn && dpAddr_q == dic_pkg::ADDR_WIN0) begin
            accessWindowZero_q <= hwdata & dic_pkg::WIN_WMASK;
         end
         if (wrEn && dpAddr_q == dic_pkg::ADDR_WIN1) begin
            accessWindowOne_q <= hwdata & dic_pkg::WIN_WMASK;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sweepCnt_q <= 5'h00;
      end else if (sweeping) begin
         sweepCnt_q <= sweepCnt_q + 5'h01;
      end else begin
         sweepCnt_q <= 5'h00;
      end
   end

   // Arrays have no reset: contents survive it and software must sweep first
   always_ff @(posedge clk) begin
      if (copyEn) begin
         tag_q[fbIdx] <= fbLine_q[27:5];
         valid_q[fbIdx] <= 1'h1;
         for (int w = 0; w < dic_pkg::WORDS; w++) begin
            data_q[{fbIdx, 2'(w)}] <= fbData_q[w];
         end
      end
      if (linvDo) begin
         valid_q[hwdata[8:4]] <= 1'h0;
      end
      if (sweeping) begin
         valid_q[sweepCnt_q] <= 1'h0;
      end
   end

   // Fill buffer flags; data beats have their own process below
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fbLine_q <= 28'h000_0000;
         fbValid_q <= 4'h0;
         fbMru_q <= 1'h0;
         fbKeep_q <= 1'h0;
      end else if (missStart) begin
         fbLine_q <= fetchAddr[31:4];
         fbValid_q <= 4'h0;
         fbMru_q <= 1'h1;
         fbKeep_q <= cacheable;
      end else begin
         if (fillBeat) begin
            fbValid_q[extWord] <= 1'h1;
         end
         // The array is newer once its slot is hit, swept or invalidated
         if ((take && arrHit && !fbHit && idx == fbIdx) || sweeping ||
            (linvDo && hwdata[8:4] == fbIdx)) begin
            fbMru_q <= 1'h0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (fillBeat) begin
         fbData_q[extWord] <= extData;
      end
   end

   // External fetch engine; a longword fetch also lands in the buffer to answer the core
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         extState_q <= dic_pkg::EXT_IDLE;
         extReq_q <= 1'h0;
         extAddr_q <= 32'h0000_0000;
         extLeft_q <= 2'h0;
      end else begin
         case (extState_q)
            dic_pkg::EXT_IDLE: begin
               if (missStart) begin
                  extReq_q <= 1'h1;
                  extAddr_q <= {fetchAddr[31:2], 2'h0};
                  extLeft_q <= isLine ? 2'h3 : 2'h0;
                  extState_q <= dic_pkg::EXT_RUN;
               end
            end
            dic_pkg::EXT_RUN: begin
               if (extAck) begin
                  if (extLeft_q == 2'h0) begin
                     extReq_q <= 1'h0;
                     extState_q <= dic_pkg::EXT_IDLE;
                  end else begin
                     extLeft_q <= extLeft_q - 2'h1;
                     extAddr_q[3:2] <= extAddr_q[3:2] + 2'h1;
                  end
               end
            end
            default: begin
               extReq_q <= 1'h0;
               extState_q <= dic_pkg::EXT_IDLE;
            end
         endcase
      end
   end

   // Answer path; a held miss is answered once its first longword lands
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fetchAck_q <= 1'h0;
         fetchData_q <= 32'h0000_0000;
         fetchAttr_q <= 3'h0;
      end else begin
         fetchAck_q <= take && (arrHit || fbHit);
         if (take && fbHit) begin
            fetchData_q <= fbData_q[wrd];
         end else if (take && arrHit) begin
            fetchData_q <= arrWord;
         end
         if (take) begin
            fetchAttr_q <= attr;
         end
      end
   end

   assign fetchAck = fetchAck_q;
   assign fetchData = fetchData_q;
   assign fetchAttr = fetchAttr_q;
   assign extReq = extReq_q;
   assign extAddr = extAddr_q;
   assign hreadyout = hreadyout_q;
   assign hrdata = hrdata_q;
   assign hresp = hresp_q;

   a_array_hit_data: assert property (@(posedge clk) disable iff (!nrst)
      (take && arrHit && !fbHit) |=> (fetchAck_q && fetchData_q == $past(arrWord)))
      else $error("array hit not answered next cycle");

   a_local_discard: assert property (@(posedge clk) disable iff (!nrst)
      (fetchReq && localMemHit && extState_q == dic_pkg::EXT_IDLE)
      |=> (!fetchAck_q && !extReq_q))
      else $error("cache acted on a local memory fetch");

   a_sweep_stall: assert property (@(posedge clk) disable iff (!nrst)
      sweeping |=> !fetchAck_q)
      else $error("fetch answered during sweep");

   a_sweep_length: assert property (@(posedge clk) disable iff (!nrst)
      ($rose(sweeping) && !ctrlWr) |-> (sweeping && sweepCnt_q == 5'h00) ##31
      (sweepCnt_q == 5'h1F) ##1 (!sweeping || $past(ctrlWr)))
      else $error("sweep did not take 32 cycles");

   a_sweep_clears: assert property (@(posedge clk) disable iff (!nrst)
      sweeping |=> !valid_q[$past(sweepCnt_q)])
      else $error("swept entry still valid");

   a_wrap_order: assert property (@(posedge clk) disable iff (!nrst)
      (fillBeat && extLeft_q != 2'h0) |=> (extReq_q &&
      extAddr_q[3:2] == $past(extAddr_q[3:2]) + 2'h1 && extAddr_q[31:4] == $past(extAddr_q[31:4])))
      else $error("fill longwords out of wrap order");

   a_beat_valid: assert property (@(posedge clk) disable iff (!nrst)
      (fillBeat && !missStart) |=> (fbValid_q[$past(extWord)] && fbData_q[$past(extWord)] ==
      $past(extData)))
      else $error("returned longword not captured");

   a_whole_line: assert property (@(posedge clk) disable iff (!nrst)
      (copyEn && !linvDo && !sweeping) |=> (valid_q[$past(fbIdx)] &&
      tag_q[$past(fbIdx)] == $past(fbLine_q[27:5]) && $past(fbValid_q) == 4'hF))
      else $error("line copied without all longwords");

   a_line_inval: assert property (@(posedge clk) disable iff (!nrst)
      linvDo |=> !valid_q[$past(hwdata[8:4])])
      else $error("line invalidate had no effect");

   a_disabled_nohit: assert property (@(posedge clk) disable iff (!nrst)
      (!enabled && fetchReq && !fbHit) |=> !fetchAck_q)
      else $error("disabled cache answered from array");

   a_miss_size: assert property (@(posedge clk) disable iff (!nrst)
      missStart |=> (extLeft_q == ($past(isLine) ? 2'h3 : 2'h0)))
      else $error("fetch size does not follow policy");
endmodule

// ### bench/dic_ext_mem.sv
`timescale 1ns/1ns
module dic_ext_mem (
   input wire logic clk,
   input wire logic nrst,
   input wire logic extReq,
   input wire logic [31:0] extAddr,
   input wire logic [3:0] lat,
   output logic extAck,
   output logic [31:0] extData
);
   logic [3:0] waitCnt;

   // A slow far end just counts idle cycles before each beat
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         extAck <= 1'b0;
         extData <= 32'h0000_0000;
         waitCnt <= 4'h0;
      end else if (extReq && !extAck && waitCnt >= lat) begin
         extAck <= 1'b1;
         extData <= {extAddr[31:2], 2'b00} ^ 32'h5A5A_5A5A;
         waitCnt <= 4'h0;
      end else begin
         extAck <= 1'b0;
         // Junk outside a beat, so a sampler that ignores the ack is caught
         extData <= ~extData;
         waitCnt <= (extReq && !extAck) ? waitCnt + 4'h1 : 4'h0;
      end
   end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic fetchReq = 1'b0;
   logic [31:0] fetchAddr = 32'h0000_0000;
   logic localMemHit = 1'b0;
   logic fetchAck, extReq, extAck, hreadyout, hresp;
   logic [31:0] fetchData, extAddr, extData, hrdata, gotData;
   logic [2:0] fetchAttr, gotAttr;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [3:0] lat = 4'h0;
   logic [31:0] beats[$];
   int lastCyc;
   int error_cnt = 0;
   int total_checks = 0;

   always #4 clk = ~clk;

   dic_icache dut (.clk(clk), .nrst(nrst), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
      .localMemHit(localMemHit), .fetchAck(fetchAck), .fetchData(fetchData),
      .fetchAttr(fetchAttr), .extReq(extReq), .extAddr(extAddr), .extAck(extAck),
      .extData(extData), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp));

   dic_ext_mem far (.clk(clk), .nrst(nrst), .extReq(extReq), .extAddr(extAddr), .lat(lat),
      .extAck(extAck), .extData(extData));

   always @(posedge clk) begin
      if (extReq === 1'b1 && extAck === 1'b1) begin
         beats.push_back(extAddr);
      end
   end

   function automatic logic [31:0] expWord(input logic [31:0] a);
      return {a[31:2], 2'b00} ^ 32'h5A5A_5A5A;
   endfunction

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic hang(input string what);
      error_cnt++;
      $display("[ERR] %0t timeout in %s", $time, what);
      print_verdict();
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chkN(input int got, input int exp, input string what);
      total_checks++;
      if (got != exp) begin
         error_cnt++;
         $display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask

   task automatic waitRdy;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         hang("bus");
      end
   endtask

   // Called just after a rising edge; returns on the edge that ends the data phase
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      htrans <= dic_pkg::HTRANS_NONSEQ;
      waitRdy();
      htrans <= 2'h0;
      hwdata <= wd;
      waitRdy();
   endtask

   task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
      ahb(1'b0, a, 32'h0000_0000);
      chk32(hrdata, exp, what);
      chk32({31'h0000_0000, hresp}, 32'h0000_0000, "okay response");
   endtask

   // Checks data always and the edge count from request to ack when expCyc is positive
   task automatic fetchChk(input logic [31:0] a, input int expCyc);
      fetchReq <= 1'b1;
      fetchAddr <= a;
      lastCyc = 0;
      do begin
         @(posedge clk);
         lastCyc++;
      end while (fetchAck !== 1'b1 && lastCyc < 300);
      if (fetchAck !== 1'b1) begin
         hang("fetch");
      end
      gotData = fetchData;
      gotAttr = fetchAttr;
      fetchReq <= 1'b0;
      @(posedge clk);
      chk32(gotData, expWord(a), "fetch data");
      if (expCyc > 0) begin
         chkN(lastCyc, expCyc, "fetch latency");
      end
   endtask

   task automatic settle;
      int n;
      n = 0;
      while (extReq !== 1'b0 && n < 200) begin
         @(posedge clk);
         n++;
      end
      if (extReq !== 1'b0) begin
         hang("fill");
      end
   endtask

   task automatic endTest(input string s);
      $display("test %s done", s);
   endtask

   initial begin
      int n;
      int polBeats[4];
      logic [31:0] polAddr[4];
      logic [31:0] attrAddr[3];
      logic [31:0] attrExp[3];
      polBeats = '{1, 4, 1, 4};
      polAddr = '{32'h0000_4C3C, 32'h0000_4D38, 32'h0000_4E38, 32'h0000_4F34};
      attrAddr = '{32'h6000_0100, 32'h7000_0200, 32'h8000_0300};
      attrExp = '{32'h0000_0001, 32'h0000_0003, 32'h0000_0006};
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rdChk(dic_pkg::ADDR_CTRL, 32'h0000_0000, "ctrl reset");
      rdChk(dic_pkg::ADDR_WIN0, 32'h0000_0000, "win0 reset");
      wrReg(8'h20, 32'hFFFF_FFFF);
      rdChk(8'h20, 32'h0000_0000, "unmapped");
      endTest("registers");
      wrReg(dic_pkg::ADDR_CTRL, 32'h0100_0000);
      fetchChk(32'h0000_0100, 0);
      chkN(int'(lastCyc > 28), 1, "stall while sweeping");
      settle();
      rdChk(dic_pkg::ADDR_CTRL, 32'h0000_0000, "sweep bit cleared");
      endTest("sweep");
      wrReg(dic_pkg::ADDR_CTRL, 32'h8000_0002);
      beats.delete();
      fetchChk(32'h0000_2018, 0);
      settle();
      chkN(beats.size(), 4, "line beats");
      for (int i = 0; i < 4; i++) begin
         chk32(beats[i], 32'h0000_2010 + 32'((8 + 4 * i) % 16), "wrap order");
      end
      lat <= 4'h5;
      fetchChk(32'h0000_3024, 0);
      chkN(int'(extReq === 1'b1), 1, "ack before fill ends");
      settle();
      lat <= 4'h0;
      beats.delete();
      fetchChk(32'h0000_2018, 2);
      chkN(beats.size(), 0, "array hit");
      endTest("fill");
      wrReg(dic_pkg::ADDR_LINE_INV, 32'h0000_0010);
      fetchChk(32'h0000_2018, 0);
      settle();
      chkN(beats.size(), 4, "refill after line clear");
      wrReg(dic_pkg::ADDR_CTRL, 32'h9000_0002);
      wrReg(dic_pkg::ADDR_LINE_INV, 32'h0000_0020);
      beats.delete();
      fetchChk(32'h0000_3024, 2);
      fetchChk(32'h0000_201C, 2);
      chkN(beats.size(), 0, "kept line and buffer hit");
      endTest("invalidate");
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rdChk(dic_pkg::ADDR_CTRL, 32'h0000_0000, "ctrl after reset");
      // No sweep on purpose: a line filled before reset must still hit
      wrReg(dic_pkg::ADDR_CTRL, 32'h8000_0002);
      beats.delete();
      fetchChk(32'h0000_3024, 2);
      chkN(beats.size(), 0, "tags kept over reset");
      endTest("reset");
      for (int i = 0; i < 4; i++) begin
         wrReg(dic_pkg::ADDR_CTRL, 32'h8000_0000 | 32'(i / 2));
         beats.delete();
         fetchChk(polAddr[i], 0);
         settle();
         chkN(beats.size(), polBeats[i], "fill size");
      end
      endTest("policy");
      localMemHit <= 1'b1;
      fetchReq <= 1'b1;
      fetchAddr <= 32'h0000_7100;
      n = 0;
      repeat (6) begin
         @(posedge clk);
         if (fetchAck !== 1'b0 || extReq !== 1'b0) begin
            n++;
         end
      end
      chkN(n, 0, "local memory claims fetch");
      fetchReq <= 1'b0;
      localMemHit <= 1'b0;
      @(posedge clk);
      endTest("local memory");
      wrReg(dic_pkg::ADDR_WIN0, 32'h6000_8044);
      wrReg(dic_pkg::ADDR_WIN1, 32'h6010_8064);
      rdChk(dic_pkg::ADDR_WIN1, 32'h6010_8064, "window readback");
      for (int i = 0; i < 3; i++) begin
         fetchChk(attrAddr[i], 0);
         chk32({29'h0, gotAttr}, attrExp[i], "attributes");
         settle();
      end
      // Noncacheable lines land in the buffer only; the third miss proves none was copied
      wrReg(dic_pkg::ADDR_CTRL, 32'h8000_0402);
      for (int i = 0; i < 3; i++) begin
         beats.delete();
         fetchChk(32'h6000_0200 + 32'(i % 2) * 32'h0000_0200, 0);
         settle();
         chkN(beats.size(), 4, "buffered noncacheable line");
      end
      endTest("attributes");
      print_verdict();
   end
endmodule
